// File: verilog/aei_regs.svh
// Register offsets, field positions and reset values of the event and interrupt block
`ifndef AEI_REGS_SVH
`define AEI_REGS_SVH

// ----------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------
`define AEI_EVENT_BASE 12'h100
`define AEI_CALIB_EVENT_OFF 12'h110
`define AEI_HALTED_EVENT_OFF 12'h114
`define AEI_UPPER_EVENT_BASE 12'h118
`define AEI_LOWER_EVENT_BASE 12'h11C
`define AEI_CHAN_STRIDE 12'h008
`define AEI_IRQ_ENABLE_OFF 12'h300
`define AEI_PENDING_OFF 12'h400

// ----------------------------------------------------------------
// Enable and flag bit positions
// ----------------------------------------------------------------
`define AEI_BIT_STARTED 0
`define AEI_BIT_BUF_FULL 1
`define AEI_BIT_TASK_DONE 2
`define AEI_BIT_RESULT_READY 3
`define AEI_BIT_CALIB 4
`define AEI_BIT_HALTED 5
`define AEI_BIT_CHAN0 6
`define AEI_NUM_EVENTS 22

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define AEI_EVENT_RESET 32'h0000_0000
`define AEI_IRQ_ENABLE_RESET 22'h00_0000

`endif

// File: verilog/aei_pkg.sv
// Types shared by the event and interrupt block
package aei_pkg;

    typedef logic [21:0] aei_flags_t;

    // One-cycle event pulses from the converter core
    typedef struct packed {
        logic started;
        logic buf_full;
        logic task_done;
        logic result_ready;
        logic calibration_complete;
        logic converter_halted;
    } aei_core_ev_s;

endpackage : aei_pkg

// File: verilog/aei_limit_cmp.sv
// Per-channel limit comparator for the latest conversion result
`timescale 1ns/10ps
`default_nettype none

module aei_limit_cmp
    import aei_pkg::*;
#(
    parameter int RES_W = 16
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic sample_valid,
    input wire logic signed [RES_W-1:0] sample,
    input wire logic signed [RES_W-1:0] upper_limit,
    input wire logic signed [RES_W-1:0] lower_limit,
    output logic upper_threshold_hit,
    output logic lower_threshold_hit
);

    // ----------------------------------------------------------------
    // Compare, registered so the flag logic sees a clean pulse
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            upper_threshold_hit <= 1'b0;
            lower_threshold_hit <= 1'b0;
        end
        else
        begin
            upper_threshold_hit <= sample_valid && (sample >= upper_limit);
            lower_threshold_hit <= sample_valid && (sample <= lower_limit);
        end
    end

endmodule : aei_limit_cmp

`default_nettype wire

// File: verilog/aei_irq_top.sv
// Event flags, interrupt enable mask and interrupt output with APB register access
//
// Behaviour
// - Channel n high flag sets when result >= upper threshold; at 0x118 + 8n.
// - Channel n low flag sets when result <= lower threshold; at 0x11C + 8n.
// - Enable register at 0x300, read-write; bit 0 gates conversion-started.
// - Enable bits 1, 2, 3 gate buffer-full, task-complete and result-ready.
// - Calibration-complete flag sets when calibration finishes; enable bit 4 gates it.
// - Halted flag sets when converter stops; enable bit 5 gates it.
// - Enable bits 6 and 7 gate channel 0 high and low limit events.
// - Flags reset to zero, read 1 when generated, cleared by writing 0 to the event register or 1 to its bit at 0x400.
// - Enable bits 8 to 21 gate channels 1 to 7, high then low.
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "aei_regs.svh"

module aei_irq_top
    import aei_pkg::*;
#(
    parameter int NCH = 8,
    parameter int RES_W = 16,
    parameter int CH_W = 3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire aei_core_ev_s core_ev,
    input wire logic signed [RES_W-1:0] result,
    input wire logic [CH_W-1:0] result_chan,
    input wire logic [NCH*RES_W-1:0] upper_limits,
    input wire logic [NCH*RES_W-1:0] lower_limits,
    output logic irq
);

    // ----------------------------------------------------------------
    // Elaboration checks
    // ----------------------------------------------------------------
    // The enable map has room for exactly eight channel pairs
    if (NCH != 8 || (1 << CH_W) < NCH || RES_W < 1 || RES_W > 32)
    begin : g_bad_param
        $error("aei_irq_top: unsupported NCH, CH_W or RES_W");
    end

    // Flag map and header must agree: six core flags, then a pair per channel
    if (`AEI_NUM_EVENTS != `AEI_BIT_CHAN0 + 2 * NCH)
    begin : g_bad_map
        $error("aei_irq_top: flag count does not match the channel count");
    end

    if ($bits(aei_flags_t) != `AEI_NUM_EVENTS)
    begin : g_bad_flags
        $error("aei_irq_top: flag vector width does not match the flag count");
    end

    if ($bits(aei_core_ev_s) != `AEI_BIT_CHAN0)
    begin : g_bad_core
        $error("aei_irq_top: core event count does not match the flag map");
    end

    // ----------------------------------------------------------------
    // Constants
    // ----------------------------------------------------------------
    localparam int NFLAGS = `AEI_NUM_EVENTS;
    localparam aei_flags_t FLAGS_RESET = aei_flags_t'(`AEI_EVENT_RESET);
    localparam aei_flags_t MASK_RESET = `AEI_IRQ_ENABLE_RESET;

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    aei_flags_t flags_r;
    aei_flags_t irq_mask_r;
    aei_flags_t ev_set;
    aei_flags_t sw_set;
    aei_flags_t sw_clr;
    logic [31:0] prdata_r;
    logic pslverr_r;
    logic [NCH-1:0] upper_hit;
    logic [NCH-1:0] lower_hit;
    logic setup_phase;
    logic access_wr;
    logic ev_sel;
    logic [11:0] ev_offs;
    logic [4:0] ev_idx;
    logic mapped;
    aei_flags_t flags_nxt;
    aei_flags_t enabled_pending;
    logic irq_nxt;
    logic [31:0] prdata_nxt;
    logic pslverr_nxt;
    logic mask_sel;
    logic pending_sel;
    logic wr_event;
    logic wr_mask;
    logic wr_pending;

    assign setup_phase = psel && !penable;
    assign access_wr = psel && penable && pwrite && !pslverr_r;

    // Event registers sit one word apart from 0x100 upward: the six core events,
    // then each channel's high and low flag, so the flag index is the word index.
    assign ev_offs = paddr - `AEI_EVENT_BASE;
    assign ev_idx = ev_offs[6:2];
    assign ev_sel = (paddr >= `AEI_EVENT_BASE) && (ev_offs[1:0] == 2'b00)
        && (ev_offs[11:2] < 10'(`AEI_NUM_EVENTS));
    assign mask_sel = (paddr == `AEI_IRQ_ENABLE_OFF);
    assign pending_sel = (paddr == `AEI_PENDING_OFF);
    assign mapped = ev_sel || mask_sel || pending_sel;

    // Write strobes: one access cycle each, unmapped writes already dropped
    assign wr_event = access_wr && ev_sel;
    assign wr_mask = access_wr && mask_sel;
    assign wr_pending = access_wr && pending_sel;

    // ----------------------------------------------------------------
    // Limit comparators, one per channel
    // ----------------------------------------------------------------
    for (genvar n = 0; n < NCH; n++)
    begin : g_chan
        // Only the channel named with the result may compare against its limits
        logic chan_valid;
        assign chan_valid = core_ev.result_ready && (result_chan == CH_W'(n));

        aei_limit_cmp #(
            .RES_W(RES_W)
        ) u_cmp (
            .pclk(pclk),
            .presetn(presetn),
            .sample_valid(chan_valid),
            .sample(result),
            .upper_limit(upper_limits[n*RES_W +: RES_W]),
            .lower_limit(lower_limits[n*RES_W +: RES_W]),
            .upper_threshold_hit(upper_hit[n]),
            .lower_threshold_hit(lower_hit[n])
        );
        assign ev_set[`AEI_BIT_CHAN0 + 2*n] = upper_hit[n];
        assign ev_set[`AEI_BIT_CHAN0 + 2*n + 1] = lower_hit[n];
    end

    assign ev_set[`AEI_BIT_STARTED] = core_ev.started;
    assign ev_set[`AEI_BIT_BUF_FULL] = core_ev.buf_full;
    assign ev_set[`AEI_BIT_TASK_DONE] = core_ev.task_done;
    assign ev_set[`AEI_BIT_RESULT_READY] = core_ev.result_ready;
    assign ev_set[`AEI_BIT_CALIB] = core_ev.calibration_complete;
    assign ev_set[`AEI_BIT_HALTED] = core_ev.converter_halted;

    // ----------------------------------------------------------------
    // Software writes to the flags
    // ----------------------------------------------------------------
    // Writing 0 to an event register clears it, writing 1 raises it,
    // which lets software exercise the interrupt path without the core.
    always_comb
    begin
        sw_set = '0;
        sw_clr = '0;
        if (wr_event)
        begin
            sw_set[ev_idx] = pwdata[0];
            sw_clr[ev_idx] = !pwdata[0];
        end
        else if (wr_pending)
        begin
            sw_clr = pwdata[21:0];
        end
    end

    // ----------------------------------------------------------------
    // Sticky flags
    // ----------------------------------------------------------------
    // A hardware event in the clearing cycle survives: set wins over clear
    for (genvar i = 0; i < NFLAGS; i++)
    begin : g_flag
        logic set_any;
        logic keep_old;
        assign set_any = sw_set[i] || ev_set[i];
        assign keep_old = flags_r[i] && !sw_clr[i];
        assign flags_nxt[i] = set_any || keep_old;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            flags_r <= FLAGS_RESET;
        end
        else
        begin
            flags_r <= flags_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt enable mask
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_mask_r <= MASK_RESET;
        end
        else if (wr_mask)
        begin
            irq_mask_r <= pwdata[21:0];
        end
    end

    // ----------------------------------------------------------------
    // Interrupt output
    // ----------------------------------------------------------------
    // Judged on the next flag state so the output tracks the flags edge for edge;
    // a mask change takes effect one edge later, the price of a registered output
    always_comb
    begin
        enabled_pending = flags_nxt & irq_mask_r;
        irq_nxt = |enabled_pending;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= irq_nxt;
        end
    end

    // ----------------------------------------------------------------
    // APB read data and error
    // ----------------------------------------------------------------
    // Captured in the setup cycle, so every access completes with no wait state
    always_comb
    begin
        prdata_nxt = prdata_r;
        pslverr_nxt = pslverr_r;
        if (setup_phase)
        begin
            pslverr_nxt = !mapped;
            if (ev_sel)
            begin
                prdata_nxt = {31'h0000_0000, flags_r[ev_idx]};
            end
            else if (mask_sel)
            begin
                prdata_nxt = {10'h000, irq_mask_r};
            end
            else if (pending_sel)
            begin
                prdata_nxt = {10'h000, flags_r};
            end
            else
            begin
                // Unmapped reads return zero alongside the error
                prdata_nxt = 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0000_0000;
        end
        else
        begin
            prdata_r <= prdata_nxt;
        end
    end

    // Error is held from setup and shown only while the access phase lasts
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr_r <= 1'b0;
        end
        else
        begin
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pslverr = pslverr_r && psel && penable;
    assign pready = 1'b1;

endmodule : aei_irq_top

`default_nettype wire

// File: testbench/aei_irq_sva.sv
// Port-level assertions for the event and interrupt block
`timescale 1ns/10ps
`default_nettype none

module aei_irq_sva
    import aei_pkg::*;
#(
    parameter int NCH = 8,
    parameter int RES_W = 16,
    parameter int CH_W = 3
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire aei_core_ev_s core_ev,
    input wire logic signed [RES_W-1:0] result,
    input wire logic [CH_W-1:0] result_chan,
    input wire logic [NCH*RES_W-1:0] upper_limits,
    input wire logic [NCH*RES_W-1:0] lower_limits,
    input wire logic irq
);
    // ----------------------------------------------------------------
    // Shadow of the enable mask, so gating can be judged from the ports
    // ----------------------------------------------------------------
    logic [21:0] mask_r;
    logic acc;
    logic mapped;
    logic [5:0] ev_v;
    logic signed [RES_W-1:0] up_sel;
    logic signed [RES_W-1:0] lo_sel;
    assign acc = psel && penable;
    assign mapped = paddr[1:0] == 2'h0 && ((paddr >= 12'h100 && paddr <= 12'h154)
        || paddr == 12'h300 || paddr == 12'h400);
    assign ev_v = {core_ev.converter_halted, core_ev.calibration_complete,
        core_ev.result_ready, core_ev.task_done, core_ev.buf_full, core_ev.started};
    assign up_sel = upper_limits[result_chan*RES_W +: RES_W];
    assign lo_sel = lower_limits[result_chan*RES_W +: RES_W];
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
            mask_r <= 22'h0;
        else if (acc && pwrite && paddr == 12'h300)
            mask_r <= pwdata[21:0];

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Compare is registered, so the flag lags the pulse by one edge
    sequence s_hit_up;
        core_ev.result_ready && result >= up_sel && mask_r[6 + 2*result_chan];
    endsequence
    sequence s_hit_low;
        core_ev.result_ready && result <= lo_sel && mask_r[7 + 2*result_chan];
    endsequence

    a_ready_always: assert property (pready)
        else $error("pready low");
    a_err_unmapped: assert property (acc |-> pslverr == !mapped)
        else $error("pslverr does not match the map");
    a_read_unmapped: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_mask_read: assert property (
        acc && !pwrite && paddr == 12'h300 |-> prdata == {10'h0, mask_r})
        else $error("mask readback wrong");
    a_event_width: assert property (
        acc && !pwrite && paddr >= 12'h100 && paddr <= 12'h154 |-> prdata[31:1] == 31'h0)
        else $error("event register upper bits set");
    a_event_irq: assert property (|(ev_v & mask_r[5:0]) |-> ##2 irq)
        else $error("enabled core event gave no interrupt");
    a_hit_upper: assert property (s_hit_up |-> ##3 irq)
        else $error("upper threshold hit gave no interrupt");
    a_hit_lower: assert property (s_hit_low |-> ##3 irq)
        else $error("lower threshold hit gave no interrupt");
    a_mask_quiet: assert property ((mask_r == 22'h0)[*2] |-> !irq)
        else $error("interrupt with empty mask");
    a_irq_cause: assert property (irq |-> $past(mask_r) != 22'h0)
        else $error("interrupt without enable");
endmodule : aei_irq_sva

`default_nettype wire

// File: testbench/aei_irq_top_test.sv
// Self-checking bench for the event and interrupt block
`timescale 1ns/10ps
`default_nettype none

module aei_irq_top_test
    import aei_pkg::*;
;
    typedef struct packed {logic [11:0] addr; logic [31:0] exp; logic err;} aei_row_s;
    localparam aei_row_s ROWS [7] = '{'{12'h110, 32'h0, 1'h0}, '{12'h114, 32'h0, 1'h0},
        '{12'h118, 32'h0, 1'h0}, '{12'h154, 32'h0, 1'h0}, '{12'h300, 32'h0, 1'h0},
        '{12'h400, 32'h0, 1'h0}, '{12'h200, 32'h0, 1'h1}};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    aei_core_ev_s core_ev;
    logic signed [15:0] result;
    logic [2:0] result_chan;
    logic [127:0] upper_limits, lower_limits;
    int n_errors, n_compared;

    aei_irq_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .core_ev, .result, .result_chan, .upper_limits,
        .lower_limits, .irq);

    initial
    begin
        pclk = 1'h0;
        forever #10 pclk = ~pclk;
    end

    task chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e)
            $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
        if (g !== e)
            n_errors++;
    endtask : chk

    // Setup then access; waits on pready rather than assuming no wait states
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb

    task pulse(input logic [5:0] v);
        core_ev <= v;
        @(posedge pclk);
        core_ev <= 6'h0;
    endtask : pulse

    task idle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : idle

    task summarize();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : summarize

    initial
    begin
        #400000;
        n_errors++;
        summarize();
    end

    // ----------------------------------------------------------------
    // Stimulus
    // ----------------------------------------------------------------
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, core_ev} = '0;
        {result, result_chan, n_errors, n_compared} = '0;
        upper_limits = {8{16'h0064}};
        lower_limits = {8{16'hFF9C}};
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        foreach (ROWS[i])
        begin
            apb(1'h0, ROWS[i].addr, 32'h0);
            chk(rd, ROWS[i].exp);
            chk({31'h0, er}, {31'h0, ROWS[i].err});
        end
        // Masked first, then enabled while the flag is still pending
        for (int i = 0; i < 6; i++)
        begin
            apb(1'h1, 12'h300, 32'h3F_FFFF ^ (32'h1 << i));
            pulse(6'h20 >> i);
            idle(2);
            chk({31'h0, irq}, 32'h0);
            apb(1'h1, 12'h300, 32'h1 << i);
            idle(2);
            chk({31'h0, irq}, 32'h1);
            apb(1'h0, 12'h100 + 12'(4 * i), 32'h0);
            chk(rd, 32'h1);
            apb(1'h1, 12'h100 + 12'(4 * i), 32'h0);
            idle(2);
            chk({31'h0, irq}, 32'h0);
        end
        // Results exactly on each threshold, every channel
        for (int n = 0; n < 8; n++)
            for (int k = 0; k < 2; k++)
            begin
                apb(1'h1, 12'h300, 32'h40 << (2 * n + k));
                result <= k ? 16'hFF9C : 16'h0064;
                result_chan <= 3'(n);
                pulse(6'h04);
                idle(3);
                chk({31'h0, irq}, 32'h1);
                apb(1'h0, 12'h118 + 12'(8 * n + 4 * k), 32'h0);
                chk(rd, 32'h1);
                apb(1'h0, 12'h11C + 12'(8 * n - 4 * k), 32'h0);
                chk(rd, 32'h0);
                apb(1'h0, 12'h400, 32'h0);
                chk(rd, 32'h8 | (32'h40 << (2 * n + k)));
                apb(1'h1, 12'h400, 32'h3F_FFFF);
                idle(2);
                chk({31'h0, irq}, 32'h0);
            end
        // Reset in mid-run with the six core flags and channel 7's low flag pending, all enabled
        apb(1'h1, 12'h300, 32'h3F_FFFF);
        pulse(6'h3F);
        idle(3);
        chk({31'h0, irq}, 32'h1);
        @(posedge pclk);
        presetn <= 1'h0;
        idle(2);
        chk({31'h0, irq}, 32'h0);
        @(posedge pclk);
        presetn <= 1'h1;
        idle(2);
        chk({31'h0, irq}, 32'h0);
        apb(1'h0, 12'h400, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 12'h300, 32'h0);
        chk(rd, 32'h0);
        apb(1'h0, 12'h114, 32'h0);
        chk(rd, 32'h0);
        summarize();
    end
endmodule : aei_irq_top_test

bind aei_irq_top aei_irq_sva #(.NCH(NCH), .RES_W(RES_W), .CH_W(CH_W)) i_sva (.pclk,
    .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .core_ev, .result, .result_chan, .upper_limits, .lower_limits, .irq);

`default_nettype wire
